// ---- pkg/btm_pkg.sv ----
// Purpose: shared constants of the boost trim and monitor register bank
// Assumes: 7-bit register addresses, 8-bit register data, 20 MHz system clock
// Notes: calibration memory holds six 5-bit phase values
package btm_pkg;
    localparam int unsigned CLK_MHZ = 20;

    localparam logic [6:0] ADDR_GATE_SUPPLY = 7'h15;
    localparam logic [6:0] ADDR_OVER_THR = 7'h1A;
    localparam logic [6:0] ADDR_UNDER_THR = 7'h1B;
    localparam logic [6:0] ADDR_TRIM = 7'h1C;
    localparam logic [6:0] ADDR_SUPPLY_MEAS = 7'h45;
    localparam logic [6:0] ADDR_DIE_TEMP = 7'h46;
    localparam logic [6:0] ADDR_TRIM_RESULT = 7'h4C;
    localparam logic [6:0] ADDR_DIAG = 7'h4F;

    localparam logic [7:0] RST_GATE_SUPPLY = 8'h5D;
    localparam logic [7:0] RST_OVER_THR = 8'hFF;
    localparam logic [7:0] RST_UNDER_THR = 8'h00;
    localparam logic [7:0] RST_TRIM = 8'h09;

    localparam int unsigned TRIM_MODE_BIT = 0;
    localparam int unsigned TRIM_FIELD_LSB = 1;
    localparam int unsigned TRIM_FIELD_MSB = 5;

    localparam logic [4:0] TRIM_NOMINAL = 5'h04;
    localparam logic [4:0] TRIM_NEG_FIRST = 5'h08;
    localparam logic [4:0] TRIM_NEG_LAST = 5'h0F;
    localparam logic [4:0] TRIM_POS_LOW_LAST = 5'h07;
    localparam logic [4:0] TRIM_POS_HIGH_FIRST = 5'h18;
    localparam logic [4:0] TRIM_TOP_FIRST = 5'h10;
    localparam logic [4:0] TRIM_TOP_LAST = 5'h11;

    localparam logic [4:0] PTR_PROGRESS = 5'h00;
    localparam logic [4:0] PTR_FIRST_VALUE = 5'h04;
    localparam logic [4:0] PTR_LAST_VALUE = 5'h0E;

    localparam logic [7:0] GATE_CODE_MIN = 8'h5D;
    localparam logic [7:0] GATE_CODE_MAX = 8'hB7;
    localparam logic [7:0] TEMP_OVER_CODE = 8'h83;

    localparam int unsigned DIAG_OUT1_OK = 7;
    localparam int unsigned DIAG_OUT2_OK = 6;
    localparam int unsigned DIAG_GATE_OK = 5;
    localparam int unsigned DIAG_OVERTEMP = 4;
    localparam int unsigned DIAG_UNDER = 3;
    localparam int unsigned DIAG_OVER = 2;
    localparam int unsigned DIAG_SERIAL = 1;
    localparam int unsigned DIAG_GATE_ERR = 0;

    localparam int unsigned CAL_ENTRIES = 6;
    localparam int unsigned CAL_WIDTH = 5;
    localparam int unsigned CAL_TIME_US = 1000;
endpackage

// ---- pkg/btm_cal_if.sv ----
// Purpose: carries calibration memory writes and reads between bank and memory
// Assumes: one write port, one registered read port
// Notes: none
`timescale 1ns/10ps
interface btm_cal_if #(parameter int unsigned AW = 3, parameter int unsigned DW = 5);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
endinterface

// ---- verilog/btm_cal_mem.sv ----
// Purpose: small store of per-phase calibration values
// Assumes: synchronous write, read data from a register
// Notes: contents are not reset; the bank reads them whether or not a calibration has finished
`timescale 1ns/10ps
module btm_cal_mem #(
    parameter int unsigned DEPTH = 6,
    parameter int unsigned AW = 3,
    parameter int unsigned DW = 5
) (
    input wire logic clk_sys_i,
    btm_cal_if.mem port
);
    logic [DW-1:0] mem_q [DEPTH];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge clk_sys_i) begin
        if (port.we && (32'(port.waddr) < DEPTH)) begin
            mem_q[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (32'(port.raddr) < DEPTH) begin
            rdata_q <= mem_q[port.raddr];
        end else begin
            rdata_q <= '0;
        end
    end

    assign port.rdata = rdata_q;
endmodule

// ---- verilog/btm_regs.sv ----
// Purpose: trim, gate supply, supply monitor, temperature and diagnostic registers
// Assumes: serial frame logic outside decodes each frame into one access cycle
// Notes: read data answers one cycle after the access; snapshots freeze while a frame is open
`timescale 1ns/10ps
module btm_regs import btm_pkg::*; #(
    parameter int unsigned CAL_CYCLES = CAL_TIME_US * CLK_MHZ
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic off_mode_i,
    input wire logic frame_active_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [6:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic acc_bad_i,
    input wire logic [1:0] out_enable_i,
    input wire logic [7:0] supply_code_i,
    input wire logic [7:0] temp_code_i,
    input wire logic output_one_regulated_i,
    input wire logic output_two_regulated_i,
    input wire logic gate_supply_good_i,
    input wire logic gate_supply_overload_i,
    input wire logic cal_wr_i,
    input wire logic [2:0] cal_wr_idx_i,
    input wire logic [btm_pkg::CAL_WIDTH-1:0] cal_wr_data_i,
    output logic [7:0] rd_data_o,
    output logic [7:0] diag_o,
    output logic [4:0] osc_trim_o,
    output logic cal_mode_o,
    output logic cal_start_o,
    output logic cal_done_o,
    output logic [7:0] gate_supply_setting_o,
    output logic measure_enable_o,
    output logic fail_silent_o
);
    import btm_pkg::*;

    localparam logic [31:0] CAL_LAST = 32'(CAL_CYCLES - 1);

    logic [7:0] gate_q, gate_d;
    logic [7:0] over_thr_q, over_thr_d;
    logic [7:0] under_thr_q, under_thr_d;
    logic [7:0] trim_q, trim_d;
    logic [7:0] supply_snap_q, temp_snap_q, result_snap_q, diag_snap_q;
    logic [7:0] rd_data_q;
    logic [7:0] diag_q;
    logic [4:0] osc_trim_q;
    logic [7:0] gate_out_q;
    logic under_q, over_q, temp_q, serial_q, overload_q;
    logic fail_q, meas_q;
    logic cal_run_q, cal_done_q, cal_start_q, cal_mode_q;
    logic [31:0] cal_cnt_q;

    btm_cal_if #(.AW(3), .DW(CAL_WIDTH)) cal_bus ();

    btm_cal_mem #(.DEPTH(CAL_ENTRIES), .AW(3), .DW(CAL_WIDTH)) u_cal_mem (
        .clk_sys_i(clk_sys_i),
        .port(cal_bus.mem)
    );

    // access decode
    // acc_write_i and acc_bad_i mean nothing unless acc_valid_i is high
    wire acc_wr = acc_valid_i & acc_write_i;
    wire acc_rd = acc_valid_i & ~acc_write_i;
    wire hit_gate = (acc_addr_i == ADDR_GATE_SUPPLY);
    wire hit_over = (acc_addr_i == ADDR_OVER_THR);
    wire hit_under = (acc_addr_i == ADDR_UNDER_THR);
    wire hit_trim = (acc_addr_i == ADDR_TRIM);
    wire hit_meas = (acc_addr_i == ADDR_SUPPLY_MEAS);
    wire hit_temp = (acc_addr_i == ADDR_DIE_TEMP);
    wire hit_result = (acc_addr_i == ADDR_TRIM_RESULT);
    wire hit_diag = (acc_addr_i == ADDR_DIAG);
    wire hit_ro = hit_meas | hit_temp | hit_result;

    // trim code legality: 01000..01111, 00000..00111, 11000..11111, 10000..10001
    wire [4:0] wr_field = acc_wdata_i[TRIM_FIELD_MSB:TRIM_FIELD_LSB];
    wire wr_norm = acc_wdata_i[TRIM_MODE_BIT];
    wire code_neg = (wr_field >= TRIM_NEG_FIRST) && (wr_field <= TRIM_NEG_LAST);
    wire code_low = (wr_field <= TRIM_POS_LOW_LAST);
    wire code_high = (wr_field >= TRIM_POS_HIGH_FIRST);
    wire code_top = (wr_field >= TRIM_TOP_FIRST) && (wr_field <= TRIM_TOP_LAST);
    wire trim_code_ok = code_neg | code_low | code_high | code_top;
    // calibration may only be (re)started when idle and gate supply is good
    wire cal_req = hit_trim & acc_wr & ~wr_norm & trim_q[TRIM_MODE_BIT];
    wire cal_allowed = gate_supply_good_i & ~cal_run_q;
    wire bad_trim = hit_trim & acc_wr & ((wr_norm & ~trim_code_ok) | (cal_req & ~cal_allowed));
    // writes to read-only registers are refused and flagged
    wire bad_ro = acc_wr & hit_ro;
    wire cmd_bad = acc_valid_i & (acc_bad_i | bad_ro | bad_trim);
    wire wr_ok = acc_wr & ~acc_bad_i & ~bad_ro & ~bad_trim;
    wire cal_go = wr_ok & cal_req;
    wire diag_clear = (wr_ok & hit_diag) | off_mode_i;

    // monitoring
    // supply flags are only trusted while measuring, so both compares are gated by it
    wire measuring = (|out_enable_i) & gate_supply_good_i;
    wire under_hit = measuring & (supply_code_i < under_thr_q);
    wire over_hit = measuring & (supply_code_i > over_thr_q);
    wire temp_hit = (temp_code_i >= TEMP_OVER_CODE);

    // result readout source selected by pointer
    // odd codes and codes outside the value range, apart from the progress code, read zero
    wire [4:0] ptr = trim_q[TRIM_FIELD_MSB:TRIM_FIELD_LSB];
    wire ptr_value = ~ptr[0] & (ptr >= PTR_FIRST_VALUE) & (ptr <= PTR_LAST_VALUE);
    wire [4:0] ptr_off = ptr - PTR_FIRST_VALUE;
    wire [7:0] result_live = (ptr == PTR_PROGRESS) ? {7'h00, cal_done_q} :
                             ptr_value ? {3'h0, cal_bus.rdata} : 8'h00;

    wire [7:0] diag_live = {output_one_regulated_i, output_two_regulated_i, gate_supply_good_i,
                            temp_q, under_q, over_q, serial_q, overload_q};

    // the calibration engine fills entries 0 to 5 in pointer order
    assign cal_bus.we = cal_wr_i;
    assign cal_bus.waddr = cal_wr_idx_i;
    assign cal_bus.wdata = cal_wr_data_i;
    // value entries sit on even pointer codes, so the offset drops its bit 0
    assign cal_bus.raddr = ptr_off[3:1];

    // writable registers
    assign gate_d = (wr_ok & hit_gate) ? acc_wdata_i : gate_q;
    assign over_thr_d = (wr_ok & hit_over) ? acc_wdata_i : over_thr_q;
    assign under_thr_d = (wr_ok & hit_under) ? acc_wdata_i : under_thr_q;
    // trim keeps its six defined bits, the two reserved bits read zero
    assign trim_d = (wr_ok & hit_trim) ? {2'b00, acc_wdata_i[5:0]} : trim_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            gate_q <= RST_GATE_SUPPLY;
            over_thr_q <= RST_OVER_THR;
            under_thr_q <= RST_UNDER_THR;
            trim_q <= RST_TRIM;
        end else begin
            gate_q <= gate_d;
            over_thr_q <= over_thr_d;
            under_thr_q <= under_thr_d;
            trim_q <= trim_d;
        end
    end

    // sticky error flags, a new event wins over the clear
    wire under_d = under_hit | (under_q & ~diag_clear);
    wire over_d = over_hit | (over_q & ~diag_clear);
    wire temp_d = temp_hit | (temp_q & ~diag_clear);
    wire serial_d = cmd_bad | (serial_q & ~diag_clear);
    wire overload_d = gate_supply_overload_i | (overload_q & ~diag_clear);
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            under_q <= 1'b0;
            over_q <= 1'b0;
            temp_q <= 1'b0;
            serial_q <= 1'b0;
            overload_q <= 1'b0;
        end else begin
            under_q <= under_d;
            over_q <= over_d;
            temp_q <= temp_d;
            serial_q <= serial_d;
            overload_q <= overload_d;
        end
    end

    // fail-silent is left only through off mode, flag clearing does not release it
    wire fail_set = under_hit | over_hit | temp_hit | gate_supply_overload_i;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            fail_q <= 1'b0;
        end else if (fail_set) begin
            fail_q <= 1'b1;
        end else if (off_mode_i) begin
            fail_q <= 1'b0;
        end
    end

    // calibration timer
    // off mode aborts a running calibration and so allows a restart
    wire cal_end = cal_run_q & (cal_cnt_q == CAL_LAST);
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || off_mode_i) begin
            cal_run_q <= 1'b0;
            cal_done_q <= 1'b0;
            cal_cnt_q <= '0;
        end else if (cal_go) begin
            cal_run_q <= 1'b1;
            cal_done_q <= 1'b0;
            cal_cnt_q <= '0;
        end else if (cal_run_q) begin
            if (cal_end) begin
                cal_run_q <= 1'b0;
                cal_done_q <= 1'b1;
            end
            cal_cnt_q <= cal_cnt_q + 32'd1;
        end
    end

    // snapshots follow live values only outside a frame
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            supply_snap_q <= 8'h00;
            temp_snap_q <= 8'h00;
            result_snap_q <= 8'h00;
            diag_snap_q <= 8'h00;
        end else if (!frame_active_i) begin
            // the supply snapshot keeps its last measured value while measuring is off
            if (measuring) begin
                supply_snap_q <= supply_code_i;
            end
            temp_snap_q <= temp_code_i;
            result_snap_q <= result_live;
            diag_snap_q <= diag_live;
        end
    end

    // read answer; a write answers with the new content, except a diagnostic write, which answers the snapshot; a bad command answers zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (1'b1)
            hit_gate: rd_mux = gate_d;
            hit_over: rd_mux = over_thr_d;
            hit_under: rd_mux = under_thr_d;
            hit_trim: rd_mux = trim_d;
            hit_meas: rd_mux = supply_snap_q;
            hit_temp: rd_mux = temp_snap_q;
            hit_result: rd_mux = result_snap_q;
            hit_diag: rd_mux = diag_snap_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // the answer holds between accesses, so a slow frame still finds it
    wire [7:0] rd_answer = cmd_bad ? 8'h00 : rd_mux;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_data_q <= 8'h00;
        end else if (acc_rd | acc_wr) begin
            rd_data_q <= rd_answer;
        end
    end

    // outputs toward the converter
    // a forbidden stored gate code stays readable, only the driven code is clamped
    wire [7:0] gate_clamped = (gate_q < GATE_CODE_MIN) ? GATE_CODE_MIN :
                              (gate_q > GATE_CODE_MAX) ? GATE_CODE_MAX : gate_q;
    wire [4:0] trim_sel = trim_q[TRIM_MODE_BIT] ? ptr : TRIM_NOMINAL;
    wire [7:0] diag_sel = frame_active_i ? diag_snap_q : diag_live;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            diag_q <= 8'h00;
            osc_trim_q <= TRIM_NOMINAL;
            cal_mode_q <= 1'b0;
            cal_start_q <= 1'b0;
            gate_out_q <= RST_GATE_SUPPLY;
            meas_q <= 1'b0;
        end else begin
            diag_q <= diag_sel;
            osc_trim_q <= trim_sel;
            cal_mode_q <= ~trim_q[TRIM_MODE_BIT];
            cal_start_q <= cal_go;
            gate_out_q <= gate_clamped;
            meas_q <= measuring;
        end
    end

    assign rd_data_o = rd_data_q;
    assign diag_o = diag_q;
    assign osc_trim_o = osc_trim_q;
    assign cal_mode_o = cal_mode_q;
    assign cal_start_o = cal_start_q;
    assign cal_done_o = cal_done_q;
    assign gate_supply_setting_o = gate_out_q;
    assign measure_enable_o = meas_q;
    assign fail_silent_o = fail_q;
endmodule

// ---- bench/btm_regs_properties.sv ----
// Purpose: port-level checks of the register bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every btm_regs instance
`timescale 1ns/10ps
module btm_regs_chk #(parameter int unsigned CAL_CYCLES = 16) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic off_mode_i,
    input wire logic frame_active_i,
    input wire logic acc_valid_i,
    input wire logic acc_bad_i,
    input wire logic [7:0] temp_code_i,
    input wire logic [7:0] rd_data_o,
    input wire logic [7:0] diag_o,
    input wire logic [4:0] osc_trim_o,
    input wire logic cal_mode_o,
    input wire logic cal_start_o,
    input wire logic cal_done_o,
    input wire logic [7:0] gate_supply_setting_o,
    input wire logic fail_silent_o
);
    localparam int CAL_MAX = CAL_CYCLES + 4;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_hot;
        (temp_code_i >= 8'h83 && !frame_active_i) [*3];
    endsequence
    sequence s_bad;
        acc_valid_i && acc_bad_i && !frame_active_i ##1 !frame_active_i [*2];
    endsequence
    sequence s_quiet;
        (frame_active_i && !acc_valid_i) [*3];
    endsequence
    a_silent_holds: assert property (fail_silent_o && !off_mode_i |=> fail_silent_o)
        else $error("fail-silent left without off mode");
    a_cal_nominal: assert property (cal_mode_o && $past(cal_mode_o) |-> osc_trim_o == 5'h04)
        else $error("trim not nominal in calibration mode");
    a_gate_range: assert property (gate_supply_setting_o >= 8'h5D && gate_supply_setting_o <= 8'hB7)
        else $error("gate supply code out of range");
    a_start_pulse: assert property (cal_start_o |=> !cal_start_o)
        else $error("calibration start longer than one cycle");
    a_cal_bound: assert property ($rose(cal_start_o) |-> ##[1:CAL_MAX] cal_done_o)
        else $error("calibration never completed");
    a_under_silent: assert property ($rose(diag_o[3]) && !off_mode_i && !$past(off_mode_i) |-> fail_silent_o)
        else $error("undervoltage without fail-silent");
    a_over_silent: assert property ($rose(diag_o[2]) && !off_mode_i && !$past(off_mode_i) |-> fail_silent_o)
        else $error("overvoltage without fail-silent");
    a_temp_flag: assert property (s_hot |=> diag_o[4])
        else $error("overtemperature flag missing");
    a_serial_flag: assert property (s_bad |=> diag_o[1])
        else $error("serial error flag missing");
    a_refuse_zero: assert property (acc_valid_i && acc_bad_i |=> rd_data_o == 8'h00)
        else $error("refused access answered nonzero");
    a_frame_frozen: assert property (s_quiet |=> $stable(diag_o))
        else $error("diagnostic byte moved inside a frame");
endmodule
bind btm_regs btm_regs_chk #(.CAL_CYCLES(CAL_CYCLES)) i_chk (.clk_sys_i, .rst_n_i, .off_mode_i,
    .frame_active_i, .acc_valid_i, .acc_bad_i, .temp_code_i, .rd_data_o, .diag_o, .osc_trim_o,
    .cal_mode_o, .cal_start_o, .cal_done_o, .gate_supply_setting_o, .fail_silent_o);

// ---- bench/btm_host_model.sv ----
// Purpose: host side issuing one register access per call
// Assumes: inputs change at the falling edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/10ps
module btm_host_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] rd_data_o,
    output logic frame_active_i,
    output logic acc_valid_i,
    output logic acc_write_i,
    output logic acc_bad_i,
    output logic [6:0] acc_addr_i,
    output logic [7:0] acc_wdata_i
);
    logic frame = 1'b0;
    assign frame_active_i = frame;
    initial begin
        {acc_valid_i, acc_write_i, acc_bad_i, acc_addr_i, acc_wdata_i} = '0;
    end
    task automatic access(input logic w, input logic bad, input logic [6:0] a, input logic [7:0] d,
        output logic [7:0] r);
        @(negedge clk_sys_i);
        {acc_valid_i, acc_write_i, acc_bad_i, acc_addr_i, acc_wdata_i} = {1'b1, w, bad, a, d};
        @(negedge clk_sys_i);
        r = rd_data_o;
        {acc_valid_i, acc_addr_i, acc_wdata_i} = {1'b0, ~a, ~d};
    endtask
endmodule

// ---- bench/btm_regs_bench.sv ----
// Purpose: self-checking bench of the register bank
// Assumes: short calibration time, random values from a fixed seed
// Notes: host accesses go through the host model
`timescale 1ns/10ps
module btm_regs_bench;
    import btm_pkg::*;
    logic clk_sys_i, rst_n_i, off_mode_i, frame_active_i, acc_valid_i, acc_write_i, acc_bad_i;
    logic [6:0] acc_addr_i;
    logic [7:0] acc_wdata_i, supply_code_i, temp_code_i, rd_data_o, diag_o, gate_supply_setting_o, rv, d;
    logic [1:0] out_enable_i;
    logic output_one_regulated_i, output_two_regulated_i, gate_supply_good_i, gate_supply_overload_i;
    logic cal_wr_i, cal_mode_o, cal_start_o, cal_done_o, measure_enable_o, fail_silent_o;
    logic [2:0] cal_wr_idx_i;
    logic [4:0] cal_wr_data_i, osc_trim_o, c, cv[6];
    logic [4:0] k[3] = '{5'h12, 5'h17, 5'h11};
    logic [6:0] a;
    int err_count = 0, num_checks = 0, cycles = 0, starts = 0;
    btm_regs #(.CAL_CYCLES(16)) i_dut (.clk_sys_i, .rst_n_i, .off_mode_i, .frame_active_i, .acc_valid_i,
        .acc_write_i, .acc_addr_i, .acc_wdata_i, .acc_bad_i, .out_enable_i, .supply_code_i, .temp_code_i,
        .output_one_regulated_i, .output_two_regulated_i, .gate_supply_good_i, .gate_supply_overload_i,
        .cal_wr_i, .cal_wr_idx_i, .cal_wr_data_i, .rd_data_o, .diag_o, .osc_trim_o, .cal_mode_o,
        .cal_start_o, .cal_done_o, .gate_supply_setting_o, .measure_enable_o, .fail_silent_o);
    btm_host_model i_host (.clk_sys_i, .rd_data_o, .frame_active_i, .acc_valid_i, .acc_write_i,
        .acc_bad_i, .acc_addr_i, .acc_wdata_i);
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cal_start_o === 1'b1) starts++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end
    function automatic logic [7:0] f_clamp(input logic [7:0] v);
        return (v < 8'h5D) ? 8'h5D : (v > 8'hB7) ? 8'hB7 : v;
    endfunction
    function automatic logic f_trim_ok(input logic [4:0] v);
        return !(v >= 5'h12 && v <= 5'h17);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic wr(input logic [6:0] ad, input logic [7:0] v);
        i_host.access(1'b1, 1'b0, ad, v, rv);
    endtask
    task automatic rdc(input logic [6:0] ad, input logic [7:0] exp);
        i_host.access(1'b0, 1'b0, ad, 8'h00, rv);
        chk(rv, exp);
    endtask
    task automatic note(input string s);
        $display("finished %s", s);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        {rst_n_i, off_mode_i, out_enable_i, output_one_regulated_i, output_two_regulated_i} = '0;
        {gate_supply_good_i, gate_supply_overload_i, cal_wr_i, cal_wr_idx_i, cal_wr_data_i} = '0;
        supply_code_i = 8'h80;
        temp_code_i = 8'h40;
        void'($urandom(32'h46ff));
        cyc(10);
        rst_n_i = 1'b1;
        rdc(ADDR_GATE_SUPPLY, 8'h5D);
        rdc(ADDR_OVER_THR, 8'hFF);
        rdc(ADDR_UNDER_THR, 8'h00);
        rdc(ADDR_TRIM, 8'h09);
        chk({3'b0, osc_trim_o}, 8'h04);
        note("reset");
        for (int i = 0; i < 9; i++) begin
            a = (i % 3 == 0) ? ADDR_GATE_SUPPLY : (i % 3 == 1) ? ADDR_OVER_THR : ADDR_UNDER_THR;
            d = (i == 0) ? 8'h5C : (i == 3) ? 8'hB8 : 8'($urandom);
            wr(a, d);
            chk(rv, d);
            rdc(a, d);
            if (a == ADDR_GATE_SUPPLY) chk(gate_supply_setting_o, f_clamp(d));
        end
        note("read write");
        for (int i = 0; i < 12; i++) begin
            c = (i < 3) ? k[i] : 5'($urandom);
            wr(ADDR_TRIM, {2'b00, c, 1'b1});
            cyc(3);
            if (f_trim_ok(c)) chk({3'b0, osc_trim_o}, {3'b0, c});
            else chk({rv[7:1], diag_o[1]}, 8'h01);
            wr(ADDR_DIAG, 8'h00);
        end
        wr(ADDR_SUPPLY_MEAS, 8'h55);
        chk(rv, 8'h00);
        wr(ADDR_UNDER_THR, 8'h40);
        wr(ADDR_OVER_THR, 8'hC0);
        i_host.access(1'b1, 1'b1, ADDR_OVER_THR, 8'h11, rv);
        cyc(3);
        chk({7'h0, diag_o[1]}, 8'h01);
        rdc(ADDR_OVER_THR, 8'hC0);
        wr(ADDR_DIAG, 8'h00);
        rdc(7'h7F, 8'h00);
        cyc(3);
        chk({7'h0, diag_o[1]}, 8'h00);
        note("trim and refusals");
        gate_supply_good_i = 1'b1;
        supply_code_i = 8'h20;
        cyc(4);
        chk({6'h0, diag_o[3], measure_enable_o}, 8'h00);
        out_enable_i = 2'b01;
        supply_code_i = 8'h40;
        cyc(4);
        chk({5'h0, diag_o[3:2], measure_enable_o}, 8'h01);
        rdc(ADDR_SUPPLY_MEAS, 8'h40);
        supply_code_i = 8'h3F;
        cyc(4);
        chk({6'h0, diag_o[3], fail_silent_o}, 8'h03);
        supply_code_i = 8'h80;
        wr(ADDR_DIAG, 8'h00);
        cyc(3);
        chk({6'h0, diag_o[3], fail_silent_o}, 8'h01);
        supply_code_i = 8'hC1;
        cyc(4);
        chk({6'h0, diag_o[2], fail_silent_o}, 8'h03);
        supply_code_i = 8'h80;
        off_mode_i = 1'b1;
        cyc(2);
        off_mode_i = 1'b0;
        cyc(3);
        chk({6'h0, diag_o[2], fail_silent_o}, 8'h00);
        note("supply monitor");
        temp_code_i = 8'h82;
        cyc(4);
        rdc(ADDR_DIE_TEMP, 8'h82);
        chk({7'h0, diag_o[4]}, 8'h00);
        i_host.frame = 1'b1;
        cyc(2);
        temp_code_i = 8'h83;
        cyc(4);
        rdc(ADDR_DIE_TEMP, 8'h82);
        chk({7'h0, diag_o[4]}, 8'h00);
        i_host.frame = 1'b0;
        cyc(4);
        rdc(ADDR_DIE_TEMP, 8'h83);
        chk({6'h0, diag_o[4], fail_silent_o}, 8'h03);
        temp_code_i = 8'h40;
        out_enable_i = 2'b00;
        for (int i = 0; i < 5; i++) begin
            {output_one_regulated_i, output_two_regulated_i, gate_supply_good_i, gate_supply_overload_i} = 4'($urandom);
            cyc(4);
            chk({5'h0, diag_o[7:5]}, {5'h0, output_one_regulated_i, output_two_regulated_i, gate_supply_good_i});
            if (gate_supply_overload_i) chk({7'h0, diag_o[0]}, 8'h01);
        end
        {gate_supply_overload_i, gate_supply_good_i, off_mode_i} = 3'b011;
        cyc(2);
        off_mode_i = 1'b0;
        note("diagnostics");
        for (int j = 0; j < 6; j++) begin
            cv[j] = 5'($urandom);
            {cal_wr_i, cal_wr_idx_i, cal_wr_data_i} = {1'b1, 3'(j), cv[j]};
            cyc(1);
            cal_wr_i = 1'b0;
        end
        wr(ADDR_TRIM, 8'h00);
        cyc(3);
        chk({2'b0, cal_mode_o, osc_trim_o}, 8'h24);
        rdc(ADDR_TRIM_RESULT, 8'h00);
        cyc(20);
        rdc(ADDR_TRIM_RESULT, 8'h01);
        chk({6'h0, cal_done_o, 1'(starts)}, 8'h03);
        for (int j = 0; j < 6; j++) begin
            wr(ADDR_TRIM, {2'b00, 5'(4 + 2 * j), 1'b0});
            cyc(3);
            rdc(ADDR_TRIM_RESULT, {3'b0, cv[j]});
        end
        note("calibration");
        summarize();
    end
endmodule
